// >>> src/dobs_defs.svh
// Constants for the disc order byte sequencer: order codes, counter values, register widths and reset values.
// Assumes inclusion once per compile unit; guarded against repeats.
`ifndef DOBS_DEFS_SVH
`define DOBS_DEFS_SVH
// ----------------------------------------
// Order codes
// ----------------------------------------
`define DOBS_ORD_SENSE 5'h04
`define DOBS_ORD_SEEK 5'h03
`define DOBS_ORD_WRITE_LOW 3'h1
// ----------------------------------------
// Byte counter values
// ----------------------------------------
`define DOBS_BK_INIT 2'h3
`define DOBS_BK_SECOND 2'h2
`define DOBS_BK_THIRD 2'h1
// ----------------------------------------
// Register widths and reset values
// ----------------------------------------
`define DOBS_TRACK_W 11
`define DOBS_SECTOR_W 4
`define DOBS_TRACK_RST 11'h000
`define DOBS_SECTOR_RST 4'h0
`define DOBS_BYTE_RST 8'h00
`endif

// >>> src/dobs_pkg.sv
// Types shared by the disc order byte sequencer.
// Assumes the constants header is compiled alongside.
package dobs_pkg;
  // Sequencer phases
  typedef enum logic [2:0] {
    DOBS_IDLE,
    DOBS_FSTROBE_FIRST,
    DOBS_FSTROBE_SECOND,
    DOBS_REQUEST,
    DOBS_ACK_WAIT,
    DOBS_TERMINAL,
    DOBS_WRITE_SVC
  } dobs_phase_t;
  // Order issued by the processor side
  typedef struct packed {
    logic load;
    logic [4:0] code;
    logic start_ok;
  } dobs_order_t;
  // Identity placed on function response lines
  typedef struct packed {
    logic [3:0] ctrl_addr;
    logic [3:0] unit_addr;
  } dobs_ident_t;
endpackage

// >>> src/dobs_sequencer.sv
// Disc order byte sequencer: sense and seek byte transfers, write order entry.
// Assumes the processor side and selection unit lines are asynchronous pins.
`timescale 1ns/1ps
`include "dobs_defs.svh"
module dobs_sequencer (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Order register load and unit identity
  input wire dobs_pkg::dobs_order_t order_in,
  input wire dobs_pkg::dobs_ident_t ident,
  // Processor byte handshake
  input wire logic byte_request_ack,
  input wire logic [7:0] data_lines_in,
  input wire logic count_done,
  output logic byte_request_strobe,
  output logic [7:0] output_byte,
  // Selection unit lines
  input wire logic track_protect_bit,
  input wire logic [3:0] current_sector_lines,
  // Status and service signalling
  output logic sense_active,
  output logic last_byte_flag,
  output logic [7:0] function_response_lines,
  output logic service_type_hi,
  output logic service_type_lo,
  output logic terminal_order_phase,
  output logic write_active,
  output logic order_in_request,
  output logic [10:0] track_reg,
  output logic [3:0] sector_reg
);
  import dobs_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic ack_s1, ack_s2, tp_s1, tp_s2, cd_s1, cd_s2;
  logic [7:0] din_s1, din_s2;
  logic [3:0] cs_s1, cs_s2;
  // Two flops on the ack, track protect, count done, data and sector inputs; order and identity are not synchronised
  always_ff @(posedge clock) begin
    ack_s1 <= byte_request_ack;
    ack_s2 <= ack_s1;
    tp_s1 <= track_protect_bit;
    tp_s2 <= tp_s1;
    cd_s1 <= count_done;
    cd_s2 <= cd_s1;
    din_s1 <= data_lines_in;
    din_s2 <= din_s1;
    cs_s1 <= current_sector_lines;
    cs_s2 <= cs_s1;
  end

  // ----------------------------------------
  // Order decode
  // ----------------------------------------
  dobs_phase_t phase, next_phase;
  logic [4:0] order_code;
  logic is_sense, is_seek, is_write;
  logic [1:0] byte_count;
  logic [7:0] staging, input_reg, holding;
  logic seek_pending;
  logic seek_steer, seek_last;
  wire order_take = order_in.load && order_in.start_ok && (phase == DOBS_IDLE);
  wire dec_sense = order_in.code == `DOBS_ORD_SENSE;
  wire dec_seek = order_in.code == `DOBS_ORD_SEEK;
  wire dec_write = order_in.code[2:0] == `DOBS_ORD_WRITE_LOW;
  wire last_byte = (is_sense && byte_count == `DOBS_BK_THIRD) || (is_seek && byte_count == `DOBS_BK_SECOND);
  wire ack_seen = ack_s2;
  wire in_request = phase == DOBS_REQUEST;
  wire req_done = in_request && byte_request_strobe && ack_seen;
  wire wait_done = (phase == DOBS_ACK_WAIT) && !ack_seen;
  wire [7:0] first_sense = {tp_s2, track_reg[6:0]};

  // ----------------------------------------
  // Phase sequencing
  // ----------------------------------------
  // Next phase selection
  always_comb begin
    next_phase = phase;
    unique case (phase)
      DOBS_IDLE: if (order_take && (dec_sense || dec_seek)) next_phase = DOBS_FSTROBE_FIRST;
        else if (order_take && dec_write) next_phase = DOBS_WRITE_SVC;
      DOBS_FSTROBE_FIRST: next_phase = DOBS_FSTROBE_SECOND;
      DOBS_FSTROBE_SECOND: next_phase = DOBS_REQUEST;
      DOBS_REQUEST: if (req_done) next_phase = last_byte ? DOBS_TERMINAL : DOBS_ACK_WAIT;
      DOBS_ACK_WAIT: if (wait_done) next_phase = DOBS_REQUEST;
      DOBS_TERMINAL: if (!ack_seen) next_phase = DOBS_IDLE;
      DOBS_WRITE_SVC: if (cd_s2) next_phase = DOBS_IDLE;
    endcase
  end

  // Phase register
  always_ff @(posedge clock) begin
    if (srst) phase <= DOBS_IDLE;
    else phase <= next_phase;
  end

  // Order latches
  always_ff @(posedge clock) begin
    if (srst) begin
      order_code <= 5'h00;
      is_sense <= 1'b0;
      is_seek <= 1'b0;
      is_write <= 1'b0;
    end else if (order_take) begin
      order_code <= order_in.code;
      is_sense <= dec_sense;
      is_seek <= dec_seek;
      is_write <= dec_write && !dec_sense && !dec_seek;
    end else if (next_phase == DOBS_IDLE) begin
      is_sense <= 1'b0;
      is_seek <= 1'b0;
      is_write <= 1'b0;
    end
  end

  // ----------------------------------------
  // Byte counter and staging
  // ----------------------------------------
  // Counter steps once per acknowledged byte other than the last, on leaving the request phase
  always_ff @(posedge clock) begin
    if (srst || order_take) byte_count <= `DOBS_BK_INIT;
    else if (req_done && !last_byte) byte_count <= byte_count - 2'h1;
  end

  // Staging register build for sense bytes two and three
  always_ff @(posedge clock) begin
    if (srst) staging <= `DOBS_BYTE_RST;
    else if (is_sense && phase == DOBS_ACK_WAIT && byte_count == `DOBS_BK_SECOND)
      staging <= {track_reg[10:7], sector_reg};
    else if (is_sense && phase == DOBS_ACK_WAIT && byte_count == `DOBS_BK_THIRD)
      staging <= {staging[7:4], cs_s2};
  end

  // ----------------------------------------
  // Strobe and output register
  // ----------------------------------------
  wire strobe_rise = in_request && !byte_request_strobe && !ack_seen;
  // Strobe held until acknowledge; output loaded with the rise on sense orders only
  always_ff @(posedge clock) begin
    if (srst) begin
      byte_request_strobe <= 1'b0;
      output_byte <= `DOBS_BYTE_RST;
    end else if (strobe_rise) begin
      byte_request_strobe <= 1'b1;
      if (is_sense) output_byte <= (byte_count == `DOBS_BK_INIT) ? first_sense : staging;
    end else if (req_done) byte_request_strobe <= 1'b0;
  end

  // ----------------------------------------
  // Seek data path
  // ----------------------------------------
  // The counter holds still on the last byte, so the byte position is latched at capture
  wire seek_capture = is_seek && req_done;
  wire steer_first = seek_steer && !seek_last;
  wire steer_second = seek_steer && seek_last;
  // Input capture at acknowledge, then holding, then steering from holding
  always_ff @(posedge clock) begin
    if (srst) begin
      input_reg <= `DOBS_BYTE_RST;
      holding <= `DOBS_BYTE_RST;
      seek_pending <= 1'b0;
      seek_steer <= 1'b0;
      seek_last <= 1'b0;
      track_reg <= `DOBS_TRACK_RST;
      sector_reg <= `DOBS_SECTOR_RST;
    end else begin
      seek_pending <= seek_capture;
      seek_steer <= seek_pending;
      if (seek_capture) begin
        input_reg <= din_s2;
        seek_last <= last_byte;
      end
      if (seek_pending) holding <= input_reg;
      if (steer_first) track_reg[6:0] <= holding[6:0];
      if (steer_second) begin
        track_reg[10:7] <= holding[7:4];
        sector_reg <= holding[3:0];
      end
    end
  end

  // ----------------------------------------
  // Status and service outputs
  // ----------------------------------------
  wire fstrobe = phase == DOBS_FSTROBE_FIRST || phase == DOBS_FSTROBE_SECOND;
  // Registered status lines
  always_ff @(posedge clock) begin
    if (srst) begin
      sense_active <= 1'b0;
      last_byte_flag <= 1'b0;
      function_response_lines <= 8'h00;
      service_type_hi <= 1'b0;
      service_type_lo <= 1'b0;
      terminal_order_phase <= 1'b0;
      write_active <= 1'b0;
      order_in_request <= 1'b0;
    end else begin
      if (fstrobe && is_sense) sense_active <= 1'b1;
      else if (next_phase == DOBS_IDLE) sense_active <= 1'b0;
      if (req_done && last_byte) last_byte_flag <= 1'b1;
      else if (order_take) last_byte_flag <= 1'b0;
      function_response_lines <= fstrobe ? {ident.ctrl_addr, ident.unit_addr} : 8'h00;
      service_type_hi <= fstrobe && is_sense;
      service_type_lo <= (fstrobe && is_seek) || phase == DOBS_WRITE_SVC;
      terminal_order_phase <= next_phase == DOBS_TERMINAL;
      write_active <= next_phase == DOBS_WRITE_SVC;
      order_in_request <= phase == DOBS_WRITE_SVC && cd_s2;
    end
  end

  // ----------------------------------------
  // Checks: handshake and sense bytes
  // ----------------------------------------
  a_strobe_hold: assert property (@(posedge clock) disable iff (srst)
    byte_request_strobe && !ack_seen |=> byte_request_strobe)
    else $error("strobe dropped early");
  a_output_stable: assert property (@(posedge clock) disable iff (srst)
    byte_request_strobe && $past(byte_request_strobe) |-> $stable(output_byte))
    else $error("output moved");
  a_first_byte: assert property (@(posedge clock) disable iff (srst)
    strobe_rise && is_sense && byte_count == `DOBS_BK_INIT |=> output_byte == $past(first_sense))
    else $error("first sense byte wrong");
  a_later_bytes: assert property (@(posedge clock) disable iff (srst)
    strobe_rise && is_sense && byte_count != `DOBS_BK_INIT |=> output_byte == $past(staging))
    else $error("staged byte not sent");
  a_stage_two: assert property (@(posedge clock) disable iff (srst)
    is_sense && phase == DOBS_ACK_WAIT && byte_count == `DOBS_BK_SECOND
    |=> staging[7:4] == $past(track_reg[10:7]) && staging[3:0] == $past(sector_reg))
    else $error("second byte not staged");
  a_third_stage: assert property (@(posedge clock) disable iff (srst)
    is_sense && phase == DOBS_ACK_WAIT && byte_count == `DOBS_BK_THIRD |=> staging[3:0] == $past(cs_s2))
    else $error("sector not staged");
  a_count_init: assert property (@(posedge clock) disable iff (srst)
    order_take |=> byte_count == 2'h3)
    else $error("counter not initialised");
  a_count_ready: assert property (@(posedge clock) disable iff (srst)
    phase == DOBS_FSTROBE_FIRST |-> byte_count == `DOBS_BK_INIT)
    else $error("counter not ready at strobe phase");
  a_count_step: assert property (@(posedge clock) disable iff (srst)
    req_done && !last_byte |=> byte_count == $past(byte_count) - 2'h1)
    else $error("counter no step");
  a_sense_count: assert property (@(posedge clock) disable iff (srst)
    req_done && is_sense && byte_count != `DOBS_BK_THIRD |=> phase == DOBS_ACK_WAIT)
    else $error("sense ended before third byte");
  a_last_term: assert property (@(posedge clock) disable iff (srst)
    req_done && last_byte |=> phase == DOBS_TERMINAL ##1 last_byte_flag)
    else $error("no terminal");
  a_sense_flag: assert property (@(posedge clock) disable iff (srst)
    phase == DOBS_FSTROBE_FIRST && is_sense |=> sense_active)
    else $error("sense flag missing");
  a_ident_shown: assert property (@(posedge clock) disable iff (srst)
    fstrobe |=> function_response_lines == $past(ident))
    else $error("identity not on response lines");
  a_sense_code: assert property (@(posedge clock) disable iff (srst)
    is_sense |-> order_code == `DOBS_ORD_SENSE)
    else $error("sense without its code");
  a_no_advance: assert property (@(posedge clock) disable iff (srst)
    in_request && !ack_seen |=> phase == DOBS_REQUEST)
    else $error("advanced without ack");

  // ----------------------------------------
  // Checks: seek and write orders
  // ----------------------------------------
  a_seek_code: assert property (@(posedge clock) disable iff (srst)
    is_seek |-> order_code == `DOBS_ORD_SEEK)
    else $error("seek without its code");
  a_hold_copy: assert property (@(posedge clock) disable iff (srst)
    seek_pending |=> holding == $past(input_reg))
    else $error("holding copy missed");
  a_seek_track: assert property (@(posedge clock) disable iff (srst)
    steer_first |=> track_reg[6:0] == $past(holding[6:0]))
    else $error("seek track bits lost");
  a_seek_sector: assert property (@(posedge clock) disable iff (srst)
    steer_second |=> track_reg[10:7] == $past(holding[7:4]) && sector_reg == $past(holding[3:0]))
    else $error("seek second byte lost");
  a_write_entry: assert property (@(posedge clock) disable iff (srst)
    order_take && dec_write |=> write_active && is_write)
    else $error("write order not entered");
  a_write_latch: assert property (@(posedge clock) disable iff (srst)
    write_active |-> is_write)
    else $error("write active without write order");
  a_order_in: assert property (@(posedge clock) disable iff (srst)
    phase == DOBS_WRITE_SVC && cd_s2 |=> order_in_request && phase == DOBS_IDLE)
    else $error("no order-in request after count done");
  c_sense_done: cover property (@(posedge clock) is_sense && phase == DOBS_TERMINAL);
  c_seek_done: cover property (@(posedge clock) is_seek && phase == DOBS_TERMINAL);
  c_write_end: cover property (@(posedge clock) order_in_request);
  c_refused_load: cover property (@(posedge clock) order_in.load && phase != DOBS_IDLE);

endmodule // dobs_sequencer

// >>> tb/dobs_proc_model.sv
// Processor-side model of the byte handshake seen by the disc order byte sequencer.
// Assumes the sequencer's clock; the bench rewinds the byte index before each seek and sense order.
`timescale 1ns/1ps
module dobs_proc_model (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Control from the bench
  input wire logic rewind,
  input wire logic slow,
  input wire logic [15:0] send_bytes,
  // Sequencer handshake
  input wire logic byte_request_strobe,
  input wire logic [7:0] output_byte,
  output logic byte_request_ack,
  output logic [7:0] data_lines_in,
  // Observations for the bench
  output logic [7:0] got [3],
  output int n_got,
  output int n_err
);
  logic [7:0] first;
  int k;
  // ----------------------------------------
  // Handshake: wait, read or drive, wait, acknowledge, hold until strobe drops
  // ----------------------------------------
  initial begin
    byte_request_ack = 1'b0;
    data_lines_in = 8'hA5;
    n_got = 0;
    n_err = 0;
    forever begin
      @(posedge clock);
      if (rewind)
        n_got = 0;
      if (byte_request_strobe === 1'b1 && srst === 1'b0) begin
        first = output_byte;
        // Strobe and output byte must hold while the processor dawdles
        repeat (slow ? 20 : 2) begin
          @(posedge clock);
          if (byte_request_strobe !== 1'b1 || output_byte !== first) n_err++;
        end
        if (n_got < 3)
          got[n_got] = output_byte;
        data_lines_in <= (n_got == 0) ? send_bytes[15:8] : send_bytes[7:0];
        repeat (2) @(posedge clock);
        byte_request_ack <= 1'b1;
        k = 0;
        while (byte_request_strobe === 1'b1 && k < 50) begin
          @(posedge clock);
          k++;
        end
        byte_request_ack <= 1'b0;
        // Released lines must not keep showing the last byte
        data_lines_in <= ~data_lines_in;
        n_got++;
      end
    end
  end
endmodule // dobs_proc_model

// >>> tb/dobs_sequencer_test.sv
// Self-checking bench for the disc order byte sequencer: seek, sense, write, refusals.
// Assumes the processor model in its own file and the shared constants header.
`timescale 1ns/1ps
`include "dobs_defs.svh"
module dobs_sequencer_test;
  import dobs_pkg::*;
  logic clock, srst, count_done, tp, rewind, slow, ack, strobe, sa, lbf, fsh, fsl, top, wa, oir;
  logic cap, term_seen, lbf_seen;
  logic [2:0] fr_sth;
  dobs_order_t order_in;
  dobs_ident_t ident;
  logic [3:0] cur_sec, sector_reg;
  logic [7:0] din, obyte, frl, fr_seen;
  logic [10:0] track_reg;
  logic [15:0] send_bytes;
  logic [7:0] got [3];
  int n_got, n_err, n_fail, comparisons, i;
  dobs_sequencer dobs_sequencer_i (.clock(clock), .srst(srst), .order_in(order_in), .ident(ident),
    .byte_request_ack(ack), .data_lines_in(din), .count_done(count_done), .byte_request_strobe(strobe),
    .output_byte(obyte), .track_protect_bit(tp), .current_sector_lines(cur_sec), .sense_active(sa),
    .last_byte_flag(lbf), .function_response_lines(frl), .service_type_hi(fsh), .service_type_lo(fsl),
    .terminal_order_phase(top), .write_active(wa), .order_in_request(oir), .track_reg(track_reg),
    .sector_reg(sector_reg));
  dobs_proc_model dobs_proc_model_i (.clock(clock), .srst(srst), .rewind(rewind), .slow(slow),
    .send_bytes(send_bytes), .byte_request_strobe(strobe), .output_byte(obyte), .byte_request_ack(ack),
    .data_lines_in(din), .got(got), .n_got(n_got), .n_err(n_err));
  // ----------------------------------------
  // Clock, watchdog and shared tasks
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    #200000;
    n_fail++;
    test_done();
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Issue one order, optionally poke a second load mid-run, follow it to idle
  task automatic run(input logic [4:0] c, input bit poke);
    order_in <= {1'b1, c, 1'b1};
    rewind <= 1'b1;
    cap = 1'b0;
    term_seen = 1'b0;
    lbf_seen = 1'b0;
    fr_seen = 8'h00;
    fr_sth = 3'h0;
    for (i = 0; i < 600 && !(term_seen && top === 1'b0); i++) begin
      @(posedge clock);
      rewind <= 1'b0;
      order_in <= (poke && i == 30) ? {1'b1, 5'(`DOBS_ORD_SEEK), 1'b1} : 7'h00;
      #1;
      if (frl !== 8'h00 && !cap) begin
        cap = 1'b1;
        fr_seen = frl;
        fr_sth = {sa, fsh, fsl};
      end
      if (top === 1'b1 && !term_seen) begin
        term_seen = 1'b1;
        lbf_seen = lbf;
      end
    end
    check(16'(term_seen), 16'h1);
    check(16'(lbf_seen), 16'h1);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    srst = 1'b1;
    order_in = 7'h00;
    ident = 8'h5C;
    count_done = 1'b0;
    tp = 1'b1;
    cur_sec = 4'h9;
    rewind = 1'b0;
    slow = 1'b0;
    send_bytes = 16'hD5A6;
    n_fail = 0;
    comparisons = 0;
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    #1;
    check(16'(track_reg), 16'h0000);
    check(16'({strobe, wa, top, lbf}), 16'h0000);
    // Seek: bit 7 of the first byte is unused
    @(posedge clock);
    run(`DOBS_ORD_SEEK, 1'b0);
    check(16'(n_got), 16'h2);
    check(16'(track_reg), 16'h0555);
    check(16'(sector_reg), 16'h6);
    check(16'(fr_seen), 16'h005C);
    check(16'(fr_sth), 16'h1);
    // Sense with a slow processor and a refused load in mid-order
    @(posedge clock);
    slow <= 1'b1;
    send_bytes <= 16'h0000;
    @(posedge clock);
    run(`DOBS_ORD_SENSE, 1'b1);
    check(16'(n_got), 16'h3);
    check(16'(got[0]), 16'h00D5);
    check(16'(got[1]), 16'h00A6);
    check(16'(got[2]), 16'h00A9);
    check(16'(fr_seen), 16'h005C);
    check(16'(fr_sth), 16'h6);
    check(16'(n_err), 16'h0);
    check(16'(track_reg), 16'h0555);
    // Unknown order code, and a sense order without start, are ignored
    @(posedge clock);
    slow <= 1'b0;
    order_in <= {1'b1, 5'h06, 1'b1};
    @(posedge clock);
    order_in <= {1'b1, `DOBS_ORD_SENSE, 1'b0};
    @(posedge clock);
    order_in <= 7'h00;
    repeat (20) @(posedge clock);
    #1;
    check(16'({strobe, wa, sa}), 16'h0);
    // Write entry and its count-done exit
    @(posedge clock);
    order_in <= {1'b1, 5'h19, 1'b1};
    @(posedge clock);
    order_in <= 7'h00;
    #1;
    for (i = 0; i < 100 && wa !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    @(posedge clock);
    #1;
    check(16'({wa, fsl}), 16'h3);
    @(posedge clock);
    count_done <= 1'b1;
    for (i = 0; i < 100 && oir !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    check(16'(oir), 16'h1);
    @(posedge clock);
    count_done <= 1'b0;
    repeat (5) @(posedge clock);
    #1;
    check(16'({wa, oir}), 16'h0);
    test_done();
  end
endmodule // dobs_sequencer_test
